// >>> hdl/trig_pkg.sv
/*
 * Shared constants and types of the channel trigger unit: the register map,
 * field positions, reset values, trigger modes and the channel setup record.
 * Assumes a single sys_clk domain and a 32-bit AXI4-Lite register bus.
 */
package trig_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_CHANNELS = 4;
	localparam int SAMPLE_W     = 16;
	localparam int HIST_DEPTH   = 3;
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 32;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFFSET    = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET  = 8'h04;
	localparam logic [ADDR_W-1:0] MASK_OFFSET    = 8'h08;
	localparam logic [ADDR_W-1:0] COUNT_OFFSET   = 8'h0c;
	localparam logic [ADDR_W-1:0] CHAN_BASE      = 8'h10;
	localparam logic [ADDR_W-1:0] CHAN_STRIDE    = 8'h10;
	localparam logic [3:0]        CH_CFG_WORD    = 4'h0;
	localparam logic [3:0]        CH_PLEVEL_WORD = 4'h4;
	localparam logic [3:0]        CH_SLEVEL_WORD = 4'h8;
	localparam logic [3:0]        CH_HYST_WORD   = 4'hc;

	// ---------------------------------------------------------------
	// Fields
	// ---------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_DIR_BIT    = 2;
	localparam int CFG_SLOPE_LSB  = 4;
	localparam int HYST_S_LSB     = 16;
	localparam int REC_STATUS_BIT = NUM_CHANNELS;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TRIG_OFF   = 2'b00,
		TRIG_BASIC = 2'b01,
		TRIG_DUAL  = 2'b10
	} trig_mode_type;

	typedef struct packed {
		trig_mode_type        mode;
		logic                 dir_neg;
		logic [1:0]           slope_sel;
		logic [SAMPLE_W-1:0]  level_p;
		logic [SAMPLE_W-1:0]  level_s;
		logic [SAMPLE_W-1:0]  hyst_p;
		logic [SAMPLE_W-1:0]  hyst_s;
	} chan_cfg_type;

	localparam chan_cfg_type CHAN_CFG_RESET = '{
		mode: TRIG_OFF, dir_neg: 1'b0, slope_sel: 2'h0,
		level_p: 16'h0000, level_s: 16'h0000, hyst_p: 16'h0000, hyst_s: 16'h0000
	};

endpackage

// >>> hdl/level_detector.sv
/*
 * Single-level crossing detector with hysteresis for one channel.
 * Assumes value is presented with sample_valid on sys_clk and that the
 * surrounding logic drives clear for one cycle on restart or reconfiguration.
 */
module level_detector
	import trig_pkg::*;
(
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic                       enable,
	input  wire logic                       clear,
	input  wire logic                       sample_valid,
	input  wire logic signed [SAMPLE_W-1:0] value,
	input  wire logic signed [SAMPLE_W-1:0] level,
	input  wire logic        [SAMPLE_W-1:0] hyst,
	input  wire logic                       dir_neg,
	output logic                            trig
);

	// ---------------------------------------------------------------
	// Comparisons
	// ---------------------------------------------------------------
	typedef enum logic {
		WAIT_ARM = 1'b0,
		ARMED    = 1'b1
	} det_state_type;

	det_state_type            state_reg;
	logic signed [17:0]       value_x;
	logic signed [17:0]       level_x;
	logic signed [17:0]       hyst_x;
	logic signed [17:0]       arm_low;
	logic signed [17:0]       arm_high;
	logic                     arm_hit;
	logic                     cross_hit;

	// Two extra bits keep level plus or minus band from wrapping.
	assign value_x  = {{2{value[SAMPLE_W-1]}}, value};
	assign level_x  = {{2{level[SAMPLE_W-1]}}, level};
	assign hyst_x   = {2'b00, hyst};
	assign arm_low  = level_x - hyst_x;
	assign arm_high = level_x + hyst_x;

	// Equal to the level is neither side: arming and firing both need strict inequality.
	assign arm_hit   = dir_neg ? (value_x > arm_high) : (value_x < arm_low); // [R10] [R3]
	assign cross_hit = dir_neg ? (value_x < level_x) : (value_x > level_x);  // [R5] [R6] [R8] [R3]

	// ---------------------------------------------------------------
	// Crossing state
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= WAIT_ARM;
			trig      <= 1'b0;
		end else begin
			trig <= 1'b0; // [R19]
			if (clear || !enable) begin
				state_reg <= WAIT_ARM; // [R9] [R19]
			end else if (sample_valid) begin
				case (state_reg)
					WAIT_ARM: begin
						if (arm_hit) begin
							state_reg <= ARMED; // [R10]
						end
					end
					ARMED: begin
						if (cross_hit) begin
							trig      <= 1'b1; // [R7]
							state_reg <= WAIT_ARM; // [R10]
						end
					end
					default: begin
						state_reg <= WAIT_ARM;
					end
				endcase
			end
		end
	end

endmodule

// >>> hdl/channel_trigger_unit.sv
/*
 * Recorder trigger unit: per-channel slope ALU and dual level detectors,
 * recorder trigger combine, sticky status with interrupt, AXI4-Lite slave.
 * Assumes samples arrive already in the sys_clk domain with a valid strobe.
 */
// Decided for this implementation: the AXI4-Lite slave port and the address map.

// What this block does
// [R1] Recorder trigger is the OR of all channel triggers.
// [R2] Each channel is off, basic single-level, or dual-level.
// [R3] Each processed sample is compared larger or smaller against a level.
// [R4] Delay registers let the ALU subtract older samples, giving slope detection.
// [R5] Trigger only on a crossing in the chosen direction, never the opposite.
// [R6] Reaching the level is no trigger; a real side change is needed.
// [R7] Trigger on the first sample beyond the level, not before it.
// [R8] A sample equal to the level never triggers.
// [R9] Signal already beyond the level at start gives no trigger.
// [R10] Re-arm only after leaving the hysteresis band.
// [R11] Dual detection uses two single-level detectors, primary and secondary.
// [R12] Basic mode uses only the primary, with selectable level and direction.
// [R13] Both levels accept any value of the input range.
// [R14] In dual mode either detector triggers the channel.
// [R15] Outward slopes trigger when leaving the range above or below.
// [R16] Inverted slopes trigger when re-entering the range.
// [R17] In dual mode the secondary direction is the primary's opposite.
// [R18] In dual mode the primary hysteresis applies to both detectors.
// [R19] Triggers are one-cycle pulses; start or reconfiguration clears detectors.
module channel_trigger_unit
	import trig_pkg::*;
(
	input  wire logic                                   sys_clk,
	input  wire logic                                   rstn,
	input  wire logic                                   sample_valid,
	input  wire logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0]  sample_data,
	output logic                                        recorder_trig,
	output logic [NUM_CHANNELS-1:0]                     channel_trig,
	output logic                                        irq,
	input  wire logic [ADDR_W-1:0]                      s_axi_awaddr,
	input  wire logic [2:0]                             s_axi_awprot,
	input  wire logic                                   s_axi_awvalid,
	output logic                                        s_axi_awready,
	input  wire logic [DATA_W-1:0]                      s_axi_wdata,
	input  wire logic [3:0]                             s_axi_wstrb,
	input  wire logic                                   s_axi_wvalid,
	output logic                                        s_axi_wready,
	output logic [1:0]                                  s_axi_bresp,
	output logic                                        s_axi_bvalid,
	input  wire logic                                   s_axi_bready,
	input  wire logic [ADDR_W-1:0]                      s_axi_araddr,
	input  wire logic [2:0]                             s_axi_arprot,
	input  wire logic                                   s_axi_arvalid,
	output logic                                        s_axi_arready,
	output logic [DATA_W-1:0]                           s_axi_rdata,
	output logic [1:0]                                  s_axi_rresp,
	output logic                                        s_axi_rvalid,
	input  wire logic                                   s_axi_rready
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CHAN_END = ADDR_W'(CHAN_BASE + NUM_CHANNELS * CHAN_STRIDE);
	chan_cfg_type [NUM_CHANNELS-1:0]    cfg_reg;
	logic [NUM_CHANNELS-1:0]            cfg_changed_reg;
	logic                               start_reg;
	logic [NUM_CHANNELS:0]              status_reg;
	logic [NUM_CHANNELS:0]              status_next;
	logic [NUM_CHANNELS:0]              mask_reg;
	logic [DATA_W-1:0]                  count_reg;
	logic [NUM_CHANNELS-1:0]            chan_hit;
	logic                               aw_held_reg;
	logic                               w_held_reg;
	logic [ADDR_W-1:0]                  waddr_reg;
	logic [DATA_W-1:0]                  wdata_reg;
	logic [3:0]                         wstrb_reg;
	logic                               do_write;
	logic                               wr_ctrl;
	logic                               wr_status;
	logic                               wr_mask;
	logic                               wr_chan;
	logic [1:0]                         wr_chan_idx;
	logic [3:0]                         wr_word;
	logic [DATA_W-1:0]                  rd_value;
	logic                               rd_ok;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction
	function automatic logic [SAMPLE_W-1:0] sat(input logic [SAMPLE_W:0] d);
		logic [SAMPLE_W-1:0] res;
		res = d[SAMPLE_W-1:0];
		if (d[SAMPLE_W] != d[SAMPLE_W-1]) begin
			res = d[SAMPLE_W] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
		end
		return res;
	endfunction

	// ---------------------------------------------------------------
	// Channel datapath
	// ---------------------------------------------------------------
	generate
		for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
			logic [HIST_DEPTH-1:0][SAMPLE_W-1:0] hist_reg;
			logic [SAMPLE_W-1:0]                 alu_value;
			logic [SAMPLE_W-1:0]                 older;
			logic                                det_clear;
			logic                                dual;
			logic                                en_p;
			logic                                en_s;
			logic                                dir_s;
			logic [SAMPLE_W-1:0]                 hyst_s_used;
			logic                                trig_p;
			logic                                trig_s;
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					hist_reg <= '0;
				end else if (sample_valid) begin
					hist_reg[0] <= sample_data[c]; // [R4]
					for (int k = 1; k < HIST_DEPTH; k++) begin
						hist_reg[k] <= hist_reg[k-1]; // [R4]
					end
				end
			end

			assign older     = hist_reg[cfg_reg[c].slope_sel - 2'd1];
			assign alu_value = (cfg_reg[c].slope_sel == 2'h0) ? sample_data[c] :
				sat({sample_data[c][SAMPLE_W-1], sample_data[c]} -
					{older[SAMPLE_W-1], older}); // [R4]
			assign det_clear   = start_reg | cfg_changed_reg[c]; // [R19]
			assign dual        = (cfg_reg[c].mode == TRIG_DUAL);
			assign en_p        = (cfg_reg[c].mode == TRIG_BASIC) || dual; // [R2] [R12]
			assign en_s        = dual; // [R12] [R14]
			assign dir_s       = ~cfg_reg[c].dir_neg; // [R17]
			// The separate secondary band is kept for other uses but ignored in dual mode.
			assign hyst_s_used = dual ? cfg_reg[c].hyst_p : cfg_reg[c].hyst_s; // [R18]

			level_detector u_primary ( // [R11]
				.sys_clk      (sys_clk),
				.rstn         (rstn),
				.enable       (en_p),
				.clear        (det_clear),
				.sample_valid (sample_valid),
				.value        (alu_value),
				.level        (cfg_reg[c].level_p),
				.hyst         (cfg_reg[c].hyst_p),
				.dir_neg      (cfg_reg[c].dir_neg),
				.trig         (trig_p)
			);

			level_detector u_secondary ( // [R11]
				.sys_clk      (sys_clk),
				.rstn         (rstn),
				.enable       (en_s),
				.clear        (det_clear),
				.sample_valid (sample_valid),
				.value        (alu_value),
				.level        (cfg_reg[c].level_s),
				.hyst         (hyst_s_used),
				.dir_neg      (dir_s),
				.trig         (trig_s)
			);

			// Upper level rising plus lower falling leaves the range; inverted, enters it.
			assign chan_hit[c] = trig_p | (trig_s & en_s); // [R14] [R15] [R16]
		end
	endgenerate

	// ---------------------------------------------------------------
	// Trigger outputs and event status
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			channel_trig  <= '0;
			recorder_trig <= 1'b0;
		end else begin
			channel_trig  <= chan_hit; // [R19]
			recorder_trig <= |chan_hit; // [R1]
		end
	end

	// Hardware set wins over a same-cycle write-one clear.
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~wdata_reg[NUM_CHANNELS:0];
		end
		status_next = status_next | {recorder_trig, channel_trig};
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			status_reg <= '0;
			irq        <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq        <= |(status_next & mask_reg);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= '0;
		end else if (start_reg) begin
			count_reg <= '0;
		end else if (recorder_trig) begin
			count_reg <= count_reg + 32'h0000_0001;
		end
	end

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	assign do_write    = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_ctrl     = do_write && (waddr_reg[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]);
	assign wr_status   = do_write && (waddr_reg[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]);
	assign wr_mask     = do_write && (waddr_reg[ADDR_W-1:2] == MASK_OFFSET[ADDR_W-1:2]);
	assign wr_chan     = do_write && (waddr_reg >= CHAN_BASE) && (waddr_reg < CHAN_END);
	assign wr_chan_idx = 2'(waddr_reg[ADDR_W-1:4] - CHAN_BASE[ADDR_W-1:4]);
	assign wr_word     = {waddr_reg[3:2], 2'b00};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			start_reg <= 1'b0;
			mask_reg  <= '0;
		end else begin
			start_reg <= wr_ctrl && wstrb_reg[0] && wdata_reg[CTRL_START_BIT]; // [R19]
			if (wr_mask) begin
				mask_reg <= (NUM_CHANNELS+1)'(merge(
					{{(DATA_W-NUM_CHANNELS-1){1'b0}}, mask_reg}, wdata_reg, wstrb_reg));
			end
		end
	end

	// Any channel register write restarts that channel's detectors.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg         <= {NUM_CHANNELS{CHAN_CFG_RESET}};
			cfg_changed_reg <= '0;
		end else begin
			cfg_changed_reg <= '0;
			if (wr_chan) begin
				cfg_changed_reg[wr_chan_idx] <= 1'b1; // [R19]
				case (wr_word)
					CH_CFG_WORD: begin
						if (wstrb_reg[0]) begin
							cfg_reg[wr_chan_idx].mode <=
								trig_mode_type'(wdata_reg[CFG_MODE_LSB +: 2]); // [R2]
							cfg_reg[wr_chan_idx].dir_neg   <= wdata_reg[CFG_DIR_BIT]; // [R12]
							cfg_reg[wr_chan_idx].slope_sel <= wdata_reg[CFG_SLOPE_LSB +: 2];
						end
					end
					CH_PLEVEL_WORD: begin
						cfg_reg[wr_chan_idx].level_p <= SAMPLE_W'(merge({16'h0000,
							cfg_reg[wr_chan_idx].level_p}, wdata_reg, wstrb_reg)); // [R13]
					end
					CH_SLEVEL_WORD: begin
						cfg_reg[wr_chan_idx].level_s <= SAMPLE_W'(merge({16'h0000,
							cfg_reg[wr_chan_idx].level_s}, wdata_reg, wstrb_reg)); // [R13]
					end
					CH_HYST_WORD: begin
						{cfg_reg[wr_chan_idx].hyst_s, cfg_reg[wr_chan_idx].hyst_p} <=
							merge({cfg_reg[wr_chan_idx].hyst_s, cfg_reg[wr_chan_idx].hyst_p},
							wdata_reg, wstrb_reg);
					end
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write channels
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			waddr_reg     <= '0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_reg   <= 1'b0;
				w_held_reg    <= 1'b0;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= (wr_ctrl || wr_status || wr_mask || wr_chan) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channels
	// ---------------------------------------------------------------
	always_comb begin
		logic [1:0] idx;
		idx      = 2'(s_axi_araddr[ADDR_W-1:4] - CHAN_BASE[ADDR_W-1:4]);
		rd_value = '0;
		rd_ok    = 1'b1;
		if (s_axi_araddr >= CHAN_BASE && s_axi_araddr < CHAN_END) begin
			case ({s_axi_araddr[3:2], 2'b00})
				CH_CFG_WORD: begin
					rd_value[CFG_MODE_LSB +: 2]  = cfg_reg[idx].mode;
					rd_value[CFG_DIR_BIT]        = cfg_reg[idx].dir_neg;
					rd_value[CFG_SLOPE_LSB +: 2] = cfg_reg[idx].slope_sel;
				end
				CH_PLEVEL_WORD: rd_value[SAMPLE_W-1:0] = cfg_reg[idx].level_p;
				CH_SLEVEL_WORD: rd_value[SAMPLE_W-1:0] = cfg_reg[idx].level_s;
				default:        rd_value = {cfg_reg[idx].hyst_s, cfg_reg[idx].hyst_p};
			endcase
		end else begin
			case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				CTRL_OFFSET:   rd_value = '0;
				STATUS_OFFSET: rd_value[NUM_CHANNELS:0] = status_reg;
				MASK_OFFSET:   rd_value[NUM_CHANNELS:0] = mask_reg;
				COUNT_OFFSET:  rd_value = count_reg;
				default:       rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_value;
				s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// >>> testbench/trig_sva.sv
/* Checker for channel_trigger_unit: trigger pulses and bus handshake order.
   Assumes only the top module's ports, one sys_clk domain, rstn active low. */
module trig_sva
	import trig_pkg::*;
(
	input wire logic                    sys_clk,
	input wire logic                    rstn,
	input wire logic                    sample_valid,
	input wire logic                    recorder_trig,
	input wire logic [NUM_CHANNELS-1:0] channel_trig,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	rec_or_a: assert property (recorder_trig == (|channel_trig))
		else $error("recorder trigger is not the OR of channels");
	pulse_one_a:
	assert property (|channel_trig |=> !(|(channel_trig & $past(channel_trig))))
		else $error("channel trigger longer than one cycle");
	rec_pulse_a: assert property (recorder_trig |=> !recorder_trig)
		else $error("recorder trigger longer than one cycle");
	trig_cause_a:
	assert property (|channel_trig |-> $past(sample_valid, 2) || $past(sample_valid, 3))
		else $error("channel trigger without a sample");
	wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	rd_resp_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during read data");
endmodule

bind channel_trigger_unit trig_sva u_trig_sva (.sys_clk, .rstn, .sample_valid, .recorder_trig,
	.channel_trig, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// >>> testbench/adc_model.sv
/* Converter sample stream: one value per channel per call of put.
   Assumes the unit's sys_clk; gap sets how slowly samples follow. */
module adc_model
	import trig_pkg::*;
(
	input  wire logic                             sys_clk,
	input  wire logic                             rstn,
	output logic                                  sample_valid,
	output logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0] sample_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sample_valid = 1'b0;
		sample_data = '0;
	end
	// Lines carry the inverse between samples, so a held value is never mistaken for one.
	task automatic put(input logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0] v, input int gap);
		@(posedge sys_clk);
		sample_valid <= 1'b1;
		sample_data <= v;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		sample_data <= ~v;
		repeat (gap) @(posedge sys_clk);
	endtask
endmodule

// >>> testbench/channel_trigger_unit_tb.sv
/* Self-checking bench for channel_trigger_unit over AXI4-Lite and the sample stream.
   Assumes trig_pkg, adc_model and the bound checker are compiled first. */
module channel_trigger_unit_tb;
	import trig_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic                                  sys_clk = 1'b0;
	logic                                  rstn = 1'b0;
	logic                                  sample_valid, recorder_trig, irq;
	logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0] sample_data;
	logic [NUM_CHANNELS-1:0]               channel_trig;
	logic [ADDR_W-1:0]                     awaddr = '0, araddr = '0;
	logic [DATA_W-1:0]                     wdata = '0, rdata;
	logic                                  awvalid = 0, wvalid = 0, bready = 0;
	logic                                  arvalid = 0, rready = 0;
	logic                                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]                            bresp, rresp;
	int                                    mismatches = 0;
	int                                    tests_run = 0;

	always #20 sys_clk = ~sys_clk;

	adc_model u_adc_model (.sys_clk, .rstn, .sample_valid, .sample_data);
	channel_trigger_unit u_channel_trigger_unit (.sys_clk, .rstn, .sample_valid, .sample_data,
		.recorder_trig, .channel_trig, .irq, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ---------------------------------------------------------------
	// Bus and check tasks
	// ---------------------------------------------------------------
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 60) begin
			mismatches++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge sys_clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		do begin
			@(posedge sys_clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 60);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
		hang(n);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge sys_clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		do begin
			@(posedge sys_clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 60);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		hang(n);
	endtask
	function automatic logic [7:0] cha(input logic [1:0] c, input logic [3:0] w);
		return CHAN_BASE + 8'(c) * CHAN_STRIDE + 8'(w);
	endfunction
	task automatic setch(input logic [1:0] c, input logic [31:0] cf, lp, ls, hy);
		wr(cha(c, CH_CFG_WORD), cf);
		wr(cha(c, CH_PLEVEL_WORD), lp);
		wr(cha(c, CH_SLEVEL_WORD), ls);
		wr(cha(c, CH_HYST_WORD), hy);
		wr(CTRL_OFFSET, 32'h1);
		wr(STATUS_OFFSET, 32'h1f);
	endtask
	task automatic step(input logic [15:0] v, input logic [4:0] e);
		logic [31:0] d;
		logic [1:0] r;
		u_adc_model.put({NUM_CHANNELS{v}}, 3);
		rd(STATUS_OFFSET, d, r);
		chk("status", d, {27'h0, e});
		chk("irq", {31'h0, irq}, {31'h0, |e});
		wr(STATUS_OFFSET, 32'h1f);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(MASK_OFFSET, d, r);
		chk("mask reset", d, 32'h0);
		rd(8'hfc, d, r);
		chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(cha(1, CH_PLEVEL_WORD), 32'h8000);
		rd(cha(1, CH_PLEVEL_WORD), d, r);
		chk("level", d, 32'h8000);
		wr(MASK_OFFSET, 32'h1f);
	endtask
	task automatic t_basic;
		logic [31:0] d;
		logic [1:0] r;
		setch(0, 32'h1, 32'd100, 32'h0, 32'd10);
		step(16'd150, 5'h00);
		step(16'd85, 5'h00);
		step(16'd100, 5'h00);
		step(16'd101, 5'h11);
		step(16'd95, 5'h00);
		step(16'd105, 5'h00);
		step(16'd85, 5'h00);
		step(16'd101, 5'h11);
		rd(COUNT_OFFSET, d, r);
		chk("count", d, 32'd2);
	endtask
	// Outward on channel 2, inward on channel 3; a huge secondary hysteresis must be unused.
	task automatic t_dual;
		setch(0, 32'h0, 32'h0, 32'h0, 32'h0);
		setch(2, 32'h2, 32'd100, 32'hff9c, 32'h7fff000a);
		setch(3, 32'h6, 32'd100, 32'hff9c, 32'h7fff000a);
		step(16'd0, 5'h00);
		step(16'd150, 5'h14);
		step(16'd0, 5'h18);
		step(16'hff6a, 5'h14);
		step(16'd0, 5'h18);
	endtask
	task automatic t_slope;
		setch(2, 32'h0, 32'h0, 32'h0, 32'h0);
		setch(3, 32'h0, 32'h0, 32'h0, 32'h0);
		setch(0, 32'h11, 32'd50, 32'h0, 32'h0);
		step(16'd0, 5'h00);
		step(16'd100, 5'h11);
		step(16'd150, 5'h00);
		step(16'd160, 5'h00);
		step(16'd300, 5'h11);
		setch(0, 32'h5, 32'h0, 32'h0, 32'h0);
		step(16'd100, 5'h00);
		step(16'hfff6, 5'h11);
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_regs();
		t_basic();
		t_dual();
		t_slope();
		wrap_up();
	end
endmodule
